/* File: bmc_top.sv */
// Serial-programmed commutation and cycle gating for a brushless motor driver.
// Assumes analog comparators and the ramp oscillator sit outside as pins.
//
// Behaviour
// - Serial bits taken on rising serial clock while chip enable is active.
// - Leading pair one-zero selects the set-point register.
// - Nine bits after the pair load set-point level and direction.
// - Registers update on the third clock edge after the falling edge of the eleventh bit.
// - Leading pair one-one selects the command register.
// - Run mode: bit three high gives PWM drive following the decode.
// - Decode uses Hall inputs, enable, direction, lock, brake and cycle gate.
// - Reset low clears set-point; with brake enable set it also forces low sides high.
// - Brake bit drives all six outputs high immediately.
// - Lock modulates only phase-one high side and phase-three low side.
// - Enable off holds every drive output off unless the brake bit or motor-reset braking is set.
// - Angle bit low uses 120 degree decode, high uses swapped 60 degree.
// - End-of-cycle pulse sets both cycle latches, raising the cycle gate.
// - PWM comparator trip resets the first cycle latch.
// - Duty follows current regulated to the latest set-point level.
// - A reset latch keeps outputs off until the next cycle pulse unless the brake bit or motor-reset braking is set.
// - Overcurrent trip resets the second latch until the next cycle.
`timescale 1ns/1ps
`default_nettype none
module bmc_top
  import bmc_pkg::*;
(
  // System clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Serial command port from the host
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic chip_enable_n_in,
  // Motor reset pin
  input wire logic motor_reset_n_in,
  // Hall position sensors
  input wire logic hall_in_one_in,
  input wire logic hall_in_two_in,
  input wire logic hall_in_three_in,
  // Oscillator and comparators
  input wire logic ramp_end_pulse_in,
  input wire logic pwm_trip_in,
  input wire logic overcurrent_trip_in,
  // Set-point to the converter
  output logic [LEVEL_BITS-1:0] setpoint_level_out,
  output logic rotation_direction_out,
  // Gate pre-driver outputs
  output logic high_side_out_one,
  output logic high_side_out_two,
  output logic high_side_out_three,
  output logic low_side_out_one,
  output logic low_side_out_two,
  output logic low_side_out_three
);

  // Number of asynchronous pins brought through the synchroniser
  localparam int unsigned PIN_COUNT = 7;
  localparam int unsigned PIN_HALL_LO = 0;
  localparam int unsigned PIN_RAMP = 3;
  localparam int unsigned PIN_PWM = 4;
  localparam int unsigned PIN_OC = 5;
  localparam int unsigned PIN_MRST = 6;
  // Idle levels: motor reset high
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 7'h40;

  // Reset release through two flip-flops
  // Entry is immediate, exit clocked
  // Hold the pin low two clocks at least
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Every other flop resets from this
  assign rst_n = rst_sync_r;

  // Serial receiver on the host's clock
  // Keeps the last whole word, flips a
  // toggle per word; a cut word is dropped
  // inside and never shows here
  // Its reset is the synced copy
  logic [WORD_BITS-1:0] rx_word;
  logic rx_toggle;

  bmc_serial_rx u_rx (
    .serial_clk_in(serial_clk_in),
    .reset_n_in(rst_n),
    // Chip enable pin is active low
    .ce_active_in(~chip_enable_n_in),
    .serial_data_in(serial_data_in),
    .word_out(rx_word),
    .word_toggle_out(rx_toggle)
  );

  // Toggle crossing: the word is held stable long before the toggle lands
  // Word and toggle change on one serial
  // edge; the word then stands a frame while
  // the toggle takes two clocks to settle,
  // so the word bus needs no synchroniser.
  // Load lands on the third clock edge.
  // Limitation: frames under three clocks
  // apart could lose a word.
  logic tog_meta_r, tog_meta_nxt;
  logic tog_sync_r, tog_sync_nxt;
  logic tog_seen_r, tog_seen_nxt;
  logic word_strobe;

  // Two flops settle, one remembers
  always_comb begin
    tog_meta_nxt = rx_toggle;
    tog_sync_nxt = tog_meta_r;
    tog_seen_nxt = tog_sync_r;
  end

  // Reset matches the receiver's toggle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
      tog_seen_r <= 1'b0;
    end else begin
      tog_meta_r <= tog_meta_nxt;
      tog_sync_r <= tog_sync_nxt;
      tog_seen_r <= tog_seen_nxt;
    end
  end

  // One clock per word, one load each
  assign word_strobe = tog_sync_r ^ tog_seen_r;

  // Pin synchronisers, two stages before any logic looks
  // Vector, low bit first: Hall three,
  // two, one, ramp end, PWM trip,
  // overcurrent, motor reset. Reset values
  // equal idle levels: no false edge.
  // A Hall code caught mid-change settles
  // a clock later; each entry names two
  // phases, so no phase shoots through.
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta_r, pin_meta_nxt;
  logic [PIN_COUNT-1:0] pin_sync_r, pin_sync_nxt;
  logic ramp_prev_r, ramp_prev_nxt;

  assign pin_raw = {motor_reset_n_in, overcurrent_trip_in, pwm_trip_in, ramp_end_pulse_in,
                    hall_in_one_in, hall_in_two_in, hall_in_three_in};

  // Shift pins in, keep the last ramp
  always_comb begin
    pin_meta_nxt = pin_raw;
    pin_sync_nxt = pin_meta_r;
    ramp_prev_nxt = pin_sync_r[PIN_RAMP];
  end

  // Motor reset idles high so its stage resets to one
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
      ramp_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
      ramp_prev_r <= ramp_prev_nxt;
    end
  end

  // The ramp is edge detected, so a wide
  // pulse sets the latches only once
  logic [2:0] hall_s;
  logic ramp_rise;
  logic pwm_trip_s;
  logic oc_trip_s;
  logic motor_reset_s;

  assign hall_s = pin_sync_r[PIN_HALL_LO +: 3];
  assign ramp_rise = pin_sync_r[PIN_RAMP] & ~ramp_prev_r;
  assign pwm_trip_s = pin_sync_r[PIN_PWM];
  assign oc_trip_s = pin_sync_r[PIN_OC];
  // The pin is active low
  assign motor_reset_s = ~pin_sync_r[PIN_MRST];

  // Register file, loaded from the crossed word
  // Word: two select bits, nine payload.
  // Set-point: direction, level MSB first.
  // Command: enable, brake, brake enable,
  // lock, angle, four spare bits kept.
  // Selects 00 and 01 load nothing.
  logic [SEL_BITS-1:0] word_sel;
  logic [PAYLOAD_BITS-1:0] word_payload;
  bmc_setpoint_t setpoint_r, setpoint_nxt;
  bmc_cmd_t command_r, command_nxt;
  logic braking_r, braking_nxt;

  // Select pair on top, payload below
  assign word_sel = rx_word[WORD_BITS-1 -: SEL_BITS];
  assign word_payload = rx_word[PAYLOAD_BITS-1:0];

  // Motor reset wins over a set-point word landing in the same cycle; a command word still loads
  // Latched braking outlives the pin until
  // the next command, so a glitch cannot
  // restart a stopped motor.
  always_comb begin
    setpoint_nxt = setpoint_r;
    command_nxt = command_r;
    braking_nxt = braking_r;
    // Direction and level load together
    if (word_strobe && (word_sel == SEL_SETPOINT)) begin
      setpoint_nxt = bmc_setpoint_t'(word_payload);
    end
    // A command also ends latched braking
    if (word_strobe && (word_sel == SEL_COMMAND)) begin
      command_nxt = bmc_cmd_t'(word_payload);
      braking_nxt = 1'b0;
    end
    // Direction is cleared too
    if (motor_reset_s) begin
      setpoint_nxt = bmc_setpoint_t'(SETPOINT_RST);
      if (command_r.brake_en) begin
        braking_nxt = 1'b1;
      end
    end
  end

  // Reset leaves enable off
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_r <= bmc_setpoint_t'(SETPOINT_RST);
      command_r <= bmc_cmd_t'(COMMAND_RST);
      braking_r <= 1'b0;
    end else begin
      setpoint_r <= setpoint_nxt;
      command_r <= command_nxt;
      braking_r <= braking_nxt;
    end
  end

  // Cycle latches: the cycle pulse sets both, comparators clear one each
  // A ramp edge sets them on the third
  // clock edge, the drive follows on the
  // fourth; a trip takes the same path.
  // A trip still standing after the set
  // clears its latch a clock later.
  logic pwm_latch_r, pwm_latch_nxt;
  logic oc_latch_r, oc_latch_nxt;
  logic cycle_gate;

  // Clears first, the set last
  always_comb begin
    pwm_latch_nxt = pwm_latch_r;
    oc_latch_nxt = oc_latch_r;
    if (pwm_trip_s) begin
      pwm_latch_nxt = 1'b0;
    end
    if (oc_trip_s) begin
      oc_latch_nxt = 1'b0;
    end
    // Set wins so a trip coinciding with the cycle start is not a lost cycle
    if (ramp_rise) begin
      pwm_latch_nxt = 1'b1;
      oc_latch_nxt = 1'b1;
    end
  end

  // Start clear: no drive before a pulse
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwm_latch_r <= 1'b0;
      oc_latch_r <= 1'b0;
    end else begin
      pwm_latch_r <= pwm_latch_nxt;
      oc_latch_r <= oc_latch_nxt;
    end
  end

  // One pulse per period at most: no path sets a latch between cycle pulses
  // Comparator noise after a trip cannot
  // reopen the gate: no double pulse.
  assign cycle_gate = pwm_latch_r & oc_latch_r;

  // Commutation decode
  // Hall code, command and direction meet
  // here; output flops give clean edges.
  // Pattern ahead of the output flops
  bmc_drive_t decoded;

  bmc_commutation u_comm (
    .hall_in({hall_s[2], hall_s[1], hall_s[0]}),
    .cmd_in(command_r),
    .rotation_direction_in(setpoint_r.rotation_direction),
    .cycle_gate_in(cycle_gate),
    .drive_out(decoded)
  );

  // Output stage; motor-reset braking overrides the decode on both sides, high sides off and low sides on
  // A high side is on while its pin is
  // low, a low side while its pin is high.
  // Brake sets every pin high.
  // Braking also takes the live pin, so the
  // clamp lands on the same edge as the flag.
  bmc_drive_t drive_r, drive_nxt;

  always_comb begin
    drive_nxt = decoded;
    // Braking beats brake bit, lock, decode
    if (braking_r || (motor_reset_s && command_r.brake_en)) begin
      drive_nxt.high_side = DRIVE_OFF.high_side;
      drive_nxt.low_side = DRIVE_BRAKE.low_side;
    end
  end

  // Reset to the all-off pattern
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= DRIVE_OFF;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  // Level feeds the external converter; the analog loop closes the current
  // The converter, amplifier and ramp
  // comparator outside make the duty cycle.
  assign setpoint_level_out = setpoint_r.level;
  assign rotation_direction_out = setpoint_r.rotation_direction;
  // Vector bit two is phase one
  assign high_side_out_one = drive_r.high_side[2];
  assign high_side_out_two = drive_r.high_side[1];
  assign high_side_out_three = drive_r.high_side[0];
  assign low_side_out_one = drive_r.low_side[2];
  assign low_side_out_two = drive_r.low_side[1];
  assign low_side_out_three = drive_r.low_side[0];

endmodule : bmc_top
`default_nettype wire

/* File: bmc_pkg.sv */
// Shared constants and carrier types for the brushless motor command block.
// Assumes serial words arrive MSB first, the select pair leading.
package bmc_pkg;

  // Serial word geometry
  localparam int unsigned WORD_BITS = 11;
  localparam int unsigned SEL_BITS = 2;
  localparam int unsigned PAYLOAD_BITS = 9;
  localparam int unsigned LEVEL_BITS = 8;
  localparam int unsigned CNT_BITS = 4;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 4'hB;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 4'h0;

  // Target select codes
  localparam logic [SEL_BITS-1:0] SEL_SETPOINT = 2'h2;
  localparam logic [SEL_BITS-1:0] SEL_COMMAND = 2'h3;

  // Reset values
  localparam logic [PAYLOAD_BITS-1:0] SETPOINT_RST = 9'h000;
  localparam logic [PAYLOAD_BITS-1:0] COMMAND_RST = 9'h000;
  localparam logic [WORD_BITS-1:0] WORD_RST = 11'h000;

  // Hall codes used by the angle translation
  localparam logic [2:0] HALL_ALL_ONE = 3'h7;
  localparam logic [2:0] HALL_ALL_ZERO = 3'h0;
  localparam logic [2:0] HALL_120_FOR_ONES = 3'h2;
  localparam logic [2:0] HALL_120_FOR_ZEROS = 3'h5;

  // Command payload, serial bit 3 in the top position
  typedef struct packed {
    logic enable;
    logic brake;
    logic brake_en;
    logic lock;
    logic angle60;
    logic [3:0] spare;
  } bmc_cmd_t;

  // Set-point payload: direction then level
  typedef struct packed {
    logic rotation_direction;
    logic [LEVEL_BITS-1:0] level;
  } bmc_setpoint_t;

  // Gate drive: high sides are on when low, low sides on when high
  typedef struct packed {
    logic [2:0] high_side;
    logic [2:0] low_side;
  } bmc_drive_t;

  localparam bmc_drive_t DRIVE_OFF = '{high_side: 3'h7, low_side: 3'h0};
  localparam bmc_drive_t DRIVE_BRAKE = '{high_side: 3'h7, low_side: 3'h7};
  localparam bmc_drive_t DRIVE_LOCK = '{high_side: 3'h3, low_side: 3'h1};

endpackage : bmc_pkg

/* File: bmc_serial_rx.sv */
// Serial word receiver running on the host's serial clock.
// Assumes the serial clock stands still while chip enable is inactive.
`timescale 1ns/1ps
`default_nettype none
module bmc_serial_rx
  import bmc_pkg::*;
(
  // Link clock and clears
  input wire logic serial_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_active_in,
  // Serial data
  input wire logic serial_data_in,
  // Finished word, toggle marks each new one
  output logic [WORD_BITS-1:0] word_out,
  output logic word_toggle_out
);

  logic clear_n;
  logic [WORD_BITS-1:0] shift_r, shift_nxt;
  logic [CNT_BITS-1:0] count_r, count_nxt;
  logic done_r, done_nxt;
  logic [WORD_BITS-1:0] word_r, word_nxt;
  logic toggle_r, toggle_nxt;

  // Dropping chip enable discards a partial word at once
  assign clear_n = reset_n_in & ce_active_in;

  // Shift on the rising edge; extra bits beyond the word are ignored
  always_comb begin
    shift_nxt = shift_r;
    count_nxt = count_r;
    if (count_r != CNT_FULL) begin
      shift_nxt = {shift_r[WORD_BITS-2:0], serial_data_in};
      count_nxt = count_r + CNT_ONE;
    end
  end

  always_ff @(posedge serial_clk_in or negedge clear_n) begin
    if (!clear_n) begin
      shift_r <= WORD_RST;
      count_r <= CNT_ZERO;
    end else begin
      shift_r <= shift_nxt;
      count_r <= count_nxt;
    end
  end

  // Hand the word over on the falling edge of the last bit
  always_comb begin
    done_nxt = done_r;
    word_nxt = word_r;
    toggle_nxt = toggle_r;
    if ((count_r == CNT_FULL) && !done_r) begin
      done_nxt = 1'b1;
      word_nxt = shift_r;
      toggle_nxt = ~toggle_r;
    end
  end

  always_ff @(negedge serial_clk_in or negedge clear_n) begin
    if (!clear_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  // Word and toggle survive chip enable so the crossing stays stable
  always_ff @(negedge serial_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_r <= WORD_RST;
      toggle_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      toggle_r <= toggle_nxt;
    end
  end

  assign word_out = word_r;
  assign word_toggle_out = toggle_r;

endmodule : bmc_serial_rx
`default_nettype wire

/* File: bmc_commutation.sv */
// Combinational commutation decode from Hall inputs and command state.
// Assumes all inputs are already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module bmc_commutation
  import bmc_pkg::*;
(
  // Position and settings
  input wire logic [2:0] hall_in,
  input wire bmc_cmd_t cmd_in,
  input wire logic rotation_direction_in,
  input wire logic cycle_gate_in,
  // Decoded gate drive
  output bmc_drive_t drive_out
);

  // 60 degree codes folded onto the 120 degree sequence
  function automatic logic [2:0] to_120(input logic [2:0] h);
    logic [2:0] r;
    r = h;
    if (h == HALL_ALL_ONE) begin
      r = HALL_120_FOR_ONES;
    end else if (h == HALL_ALL_ZERO) begin
      r = HALL_120_FOR_ZEROS;
    end
    return r;
  endfunction : to_120

  logic [2:0] pos;
  logic [2:0] src;
  logic [2:0] snk;

  always_comb begin
    // Sensor two and three pins are swapped in the 60 degree wiring
    pos = cmd_in.angle60 ? to_120({hall_in[2], hall_in[0], hall_in[1]}) : hall_in;
    src = 3'h0;
    snk = 3'h0;
    case (pos)
      3'h4: begin src = 3'h4; snk = 3'h2; end
      3'h6: begin src = 3'h4; snk = 3'h1; end
      3'h2: begin src = 3'h2; snk = 3'h1; end
      3'h3: begin src = 3'h2; snk = 3'h4; end
      3'h1: begin src = 3'h1; snk = 3'h4; end
      3'h5: begin src = 3'h1; snk = 3'h2; end
      default: begin src = 3'h0; snk = 3'h0; end
    endcase
    // Brake beats disable, lock beats Hall decode
    if (cmd_in.brake) begin
      drive_out = DRIVE_BRAKE;
    end else if (!cmd_in.enable || !cycle_gate_in) begin
      drive_out = DRIVE_OFF;
    end else if (cmd_in.lock) begin
      drive_out = DRIVE_LOCK;
    end else if (rotation_direction_in) begin
      drive_out.high_side = ~snk;
      drive_out.low_side = src;
    end else begin
      drive_out.high_side = ~src;
      drive_out.low_side = snk;
    end
  end

endmodule : bmc_commutation
`default_nettype wire

/* File: bmc_host.sv */
// Host model driving the three-wire serial command port.
// Assumes the bench calls send_word one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module bmc_host (
  // Serial port toward the device
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic chip_enable_n_out
);
  // Idle port: clock parked low, chip enable inactive
  initial begin
    serial_clk_out = 1'h0;
    serial_data_out = 1'h1;
    chip_enable_n_out = 1'h1;
  end

  // One frame, 64 ns bit period, MSB (select pair) first
  task automatic send_word(input logic [10:0] w, input int nbits);
    chip_enable_n_out = 1'h0;
    #32;
    for (int i = 10; i > 10 - nbits; i--) begin
      serial_data_out = w[i];
      #32;
      serial_clk_out = 1'h1;
      #32;
      serial_clk_out = 1'h0;
    end
    #32;
    chip_enable_n_out = 1'h1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    serial_data_out = ~serial_data_out;
  endtask : send_word
endmodule : bmc_host
`default_nettype wire

/* File: bmc_top_sva.sv */
// Port-level checker for the motor command block, bound to bmc_top.
// Assumes trips and ramp pulse are the only causes of gating.
`timescale 1ns/1ps
`default_nettype none
module bmc_top_sva
  import bmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Watched inputs
  input wire logic chip_enable_n_in,
  input wire logic motor_reset_n_in,
  input wire logic ramp_end_pulse_in,
  input wire logic pwm_trip_in,
  input wire logic overcurrent_trip_in,
  // Watched outputs
  input wire logic [LEVEL_BITS-1:0] setpoint_level_out,
  input wire logic high_side_out_one,
  input wire logic high_side_out_two,
  input wire logic high_side_out_three,
  input wire logic low_side_out_one,
  input wire logic low_side_out_two,
  input wire logic low_side_out_three
);
  logic [2:0] hs_w;
  logic [2:0] ls_w;
  // Gate pins gathered per side, phase one on the left
  assign hs_w = {high_side_out_one, high_side_out_two, high_side_out_three};
  assign ls_w = {low_side_out_one, low_side_out_two, low_side_out_three};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // Trip held long enough to cover sync latency and a late ramp edge
  sequence s_pwm_hold; (pwm_trip_in && !ramp_end_pulse_in)[*8]; endsequence
  sequence s_oc_hold; (overcurrent_trip_in && !ramp_end_pulse_in)[*8]; endsequence

  property p_pwm_off; s_pwm_hold |-> hs_w == 3'h7; endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("high side on while pwm trip held");
  property p_oc_off; s_oc_hold |-> hs_w == 3'h7; endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("high side on while overcurrent held");
  property p_no_shoot; (~hs_w & ls_w) == 3'h0; endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both switches of one phase on");
  property p_one_pair; ls_w != 3'h7 |-> $onehot0(~hs_w) && $onehot0(ls_w); endproperty
  a_one_pair: assert property (p_one_pair)
    else $error("more than one switch per side on");
  property p_brake_pat; ls_w == 3'h7 |-> hs_w == 3'h7; endproperty
  a_brake_pat: assert property (p_brake_pat)
    else $error("brake pattern with a high side on");
  property p_idle_rst; $rose(reset_n_in) |-> (hs_w == 3'h7 && ls_w == 3'h0)[*4]; endproperty
  a_idle_rst: assert property (p_idle_rst)
    else $error("drive not off after reset");
  property p_mrst_clear; (!motor_reset_n_in)[*5] |-> setpoint_level_out == 8'h00; endproperty
  a_mrst_clear: assert property (p_mrst_clear)
    else $error("level not cleared by motor reset");
  property p_level_chg;
    $changed(setpoint_level_out) |-> chip_enable_n_in || setpoint_level_out == 8'h00;
  endproperty
  a_level_chg: assert property (p_level_chg)
    else $error("level changed inside a frame");
endmodule : bmc_top_sva

bind bmc_top bmc_top_sva u_sva (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .chip_enable_n_in(chip_enable_n_in),
  .motor_reset_n_in(motor_reset_n_in),
  .ramp_end_pulse_in(ramp_end_pulse_in),
  .pwm_trip_in(pwm_trip_in),
  .overcurrent_trip_in(overcurrent_trip_in),
  .setpoint_level_out(setpoint_level_out),
  .high_side_out_one(high_side_out_one),
  .high_side_out_two(high_side_out_two),
  .high_side_out_three(high_side_out_three),
  .low_side_out_one(low_side_out_one),
  .low_side_out_two(low_side_out_two),
  .low_side_out_three(low_side_out_three)
);
`default_nettype wire

/* File: bmc_top_tb.sv */
// Self-checking bench for bmc_top against an integer reference model.
// Assumes bmc_host drives the serial port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module bmc_top_tb;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic motor_reset_n = 1'h1;
  logic ramp = 1'h0;
  logic pwm = 1'h0;
  logic oc = 1'h0;
  logic [2:0] hall = 3'h0;
  logic [31:0] seed = 32'he3aec91a;
  logic [31:0] r;
  wire logic sclk;
  wire logic sdata;
  wire logic ce_n;
  logic [7:0] level_w;
  logic dir_w;
  logic hs1, hs2, hs3, ls1, ls2, ls3;
  logic [5:0] act;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Reference state
  int exp_level = 0;
  int exp_dir = 0;
  int cmd = 0;
  int brk = 0;
  int gate = 0;

  assign act = {hs1, hs2, hs3, ls1, ls2, ls3};

  // 40 MHz system clock
  always #12.5 clk_in = ~clk_in;

  bmc_host host (.serial_clk_out(sclk), .serial_data_out(sdata), .chip_enable_n_out(ce_n));

  bmc_top DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .serial_clk_in(sclk), .serial_data_in(sdata), .chip_enable_n_in(ce_n),
    .motor_reset_n_in(motor_reset_n),
    .hall_in_one_in(hall[2]), .hall_in_two_in(hall[1]), .hall_in_three_in(hall[0]),
    .ramp_end_pulse_in(ramp), .pwm_trip_in(pwm), .overcurrent_trip_in(oc),
    .setpoint_level_out(level_w), .rotation_direction_out(dir_w),
    .high_side_out_one(hs1), .high_side_out_two(hs2), .high_side_out_three(hs3),
    .low_side_out_one(ls1), .low_side_out_two(ls2), .low_side_out_three(ls3)
  );

  // Hang guard, far above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task results();
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  task check(input string what, input int e, input logic [8:0] g);
    n_checks++;
    if (g !== 9'(e)) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, 9'(e), g);
    end
  endtask : check

  function automatic logic [10:0] cmd_w(logic en, logic bk, logic be, logic lk, logic a6);
    return {2'h3, en, bk, be, lk, a6, 4'h0};
  endfunction : cmd_w

  function automatic logic [10:0] sp_w(logic d, logic [7:0] l);
    return {2'h2, d, l};
  endfunction : sp_w

  // Pin-level drive {hs1,hs2,hs3,ls1,ls2,ls3}; high side low means on
  function automatic logic [5:0] exp_drive();
    int c, hi, lo, t;
    hi = 0;
    lo = 0;
    if (brk != 0 || cmd[7]) return 6'h3F;
    if (!cmd[8] || gate == 0) return 6'h38;
    if (cmd[5]) begin
      hi = 1;
      lo = 3;
    end else begin
      c = cmd[4] ? {hall[2], hall[0], hall[1]} : hall;
      if (cmd[4] && c == 7) c = 2;
      if (cmd[4] && c == 0) c = 5;
      case (c)
        4: begin hi = 1; lo = 2; end
        6: begin hi = 1; lo = 3; end
        2: begin hi = 2; lo = 3; end
        3: begin hi = 2; lo = 1; end
        1: begin hi = 3; lo = 1; end
        5: begin hi = 3; lo = 2; end
        default: hi = 0;
      endcase
      if (exp_dir != 0) begin
        t = hi;
        hi = lo;
        lo = t;
      end
    end
    if (hi == 0) return 6'h38;
    return {~(3'h4 >> (hi - 1)), 3'h4 >> (lo - 1)};
  endfunction : exp_drive

  // Send a frame and update the model when it is complete
  task put(input logic [10:0] w, input int nbits);
    host.send_word(w, nbits);
    if (nbits == 11 && w[10:9] == 2'h2) begin
      exp_level = w[7:0];
      exp_dir = w[8];
    end
    if (nbits == 11 && w[10:9] == 2'h3) begin
      cmd = w[8:0];
      brk = 0;
    end
    tick(12);
  endtask : put

  task chk_sp();
    check("level", exp_level, {1'h0, level_w});
    check("direction", exp_dir, {8'h00, dir_w});
  endtask : chk_sp

  task chk_drv();
    check("drive", exp_drive(), {3'h0, act});
  endtask : chk_drv

  task pulse();
    ramp = 1'h1;
    tick(2);
    ramp = 1'h0;
    gate = 1;
    tick(6);
  endtask : pulse

  // Trip, check the gate is closed, then release the comparator
  task trip(input logic kind);
    if (kind) oc = 1'h1;
    else pwm = 1'h1;
    tick(8);
    gate = 0;
    chk_drv();
    pwm = 1'h0;
    oc = 1'h0;
    tick(2);
  endtask : trip

  initial begin
    tick(6);
    reset_n_in = 1'h1;
    tick(4);
    chk_sp();
    pulse();
    chk_drv();
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      put(sp_w(r[8], r[7:0]), 11);
      chk_sp();
    end
    put({2'h1, 9'h1FF}, 11);
    chk_sp();
    put({2'h0, 9'h1FF}, 11);
    chk_sp();
    put(sp_w(1'h1, 8'hA5), 8);
    chk_sp();
    put(cmd_w(1'h0, 1'h0, 1'h0, 1'h0, 1'h0), 11);
    pulse();
    chk_drv();
    // Every Hall code in both angle modes and both directions
    for (int m = 0; m < 4; m++) begin
      put(sp_w(m[0], 8'h40), 11);
      put(cmd_w(1'h1, 1'h0, 1'h0, 1'h0, m[1]), 11);
      for (int h = 0; h < 8; h++) begin
        hall = h[2:0];
        tick(4);
        pulse();
        chk_drv();
        trip(h[0]);
      end
    end
    put(cmd_w(1'h1, 1'h0, 1'h0, 1'h1, 1'h0), 11);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      hall = r[2:0];
      tick(4);
      pulse();
      chk_drv();
    end
    trip(1'h0);
    put(cmd_w(1'h1, 1'h1, 1'h0, 1'h0, 1'h0), 11);
    chk_drv();
    put(cmd_w(1'h1, 1'h0, 1'h1, 1'h0, 1'h0), 11);
    put(sp_w(1'h0, 8'h7E), 11);
    pulse();
    motor_reset_n = 1'h0;
    tick(6);
    motor_reset_n = 1'h1;
    exp_level = 0;
    exp_dir = 0;
    brk = 1;
    tick(4);
    check("level", exp_level, {1'h0, level_w});
    chk_drv();
    put(cmd_w(1'h1, 1'h0, 1'h0, 1'h0, 1'h0), 11);
    pulse();
    chk_drv();
    // Mid-run reset: all back to idle
    put(sp_w(1'h1, 8'h3C), 11);
    chk_sp();
    reset_n_in = 1'h0;
    tick(3);
    reset_n_in = 1'h1;
    cmd = 0;
    exp_level = 0;
    exp_dir = 0;
    gate = 0;
    tick(4);
    chk_sp();
    pulse();
    chk_drv();
    results();
  end
endmodule : bmc_top_tb
`default_nettype wire
